// *** core/hvm_regs.sv ***
/*
  High-voltage live monitor and change-status registers, read indirectly
  through a command register and a data register.
  Assumes raw conditions arrive asynchronously from the analog side and
  that configuration strobes and commands come from clk-domain logic.
*/
// What this block does
// R1: Bit 7 shows wake pin in input mode
// R2: Bit 6 shows thermal shutdown occurred
// R3: Bit 5 shows aux pin in input mode
// R4: Bit 4 shows voltage buffer enabled
// R5: Bit 3 low-voltage flag, enabled, clears below
// R6: Flag set again only by re-enabling function
// R7: Bit 2 bus short, cleared by config write
// R8: Bit 1 aux short, cleared by config write
// R9: Bit 0 wake driver short flag
// R10: Status records monitor bit changes, resets zero
// R11: Status reached only via command and data
// R12: Interrupt copies status into data automatically
// R13: Software reads status on interrupt or by read-status command
// R14: Busy held 10 us during transfer
// R15: Monitor read-only, resets zero, read via data
// R16: Status bits latch until transferred out
// R17: Interrupt raised when status set and enabled
`timescale 1ns/100ps
module hvm_regs
  import hvm_pkg::*;
#(
  parameter int XFER_CNT = XFER_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire hvm_cond_t  cond_raw,
  input  wire hvm_cfg_t   cfg,
  input  wire logic       irq_enable,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_code,
  output logic      [7:0] hv_data_reg,
  output logic      [1:0] hv_command_reg,
  output logic            hv_interrupt_line,
  output logic      [7:0] hv_live_monitor,
  output logic      [7:0] hv_change_status
);

  hvm_cond_t             sync1, sync2;
  logic      [7:0]       mon, next_mon;
  logic      [7:0]       sta, next_sta;
  logic      [7:0]       data, next_data;
  logic                  low_voltage_flag, next_lvf;
  logic      [2:0]       shorts, next_shorts;
  logic                  hot, next_hot;
  hvm_state_t            state, next_state;
  logic      [CNT_W-1:0] cnt, next_cnt;
  logic                  sta_sel, next_sta_sel;
  logic                  fail, next_fail;
  logic      [7:0]       mon_view;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= cond_raw;
      sync2 <= sync1;
    end
  end

  // Sticky flags, wake short excepted: set wins over clear in the same cycle
  always_comb begin
    next_hot    = hot | sync2.over_temp; // R2
    next_shorts = shorts;
    if (cfg.short_clear) begin
      next_shorts[MON_BUS_SHORT] = 1'b0; // R7
      next_shorts[MON_AUX_SHORT] = 1'b0; // R8
    end
    next_shorts[MON_BUS_SHORT]  = next_shorts[MON_BUS_SHORT]
                                  | sync2.bus_short; // R7
    next_shorts[MON_AUX_SHORT]  = next_shorts[MON_AUX_SHORT]
                                  | sync2.aux_short; // R8
    next_shorts[MON_WAKE_SHORT] = sync2.wake_short; // R9
    // Flag rearms on re-enable, drops on supply dip and stays down
    if (cfg.lvf_enable_wr && cfg.lvf_enable)
      next_lvf = 1'b1; // R6
    else if (!cfg.lvf_enable || !sync2.lv_ok)
      next_lvf = 1'b0; // R5
    else
      next_lvf = low_voltage_flag; // R6
  end

  // Live monitor view; pin readback only in pin input mode
  always_comb begin
    mon_view = MON_RESET;
    mon_view[MON_WAKE_PIN]  = cfg.pin_input_mode & sync2.wake_pin;   // R1
    mon_view[MON_OVERTEMP]  = next_hot;                              // R2
    mon_view[MON_AUX_PIN]   = cfg.pin_input_mode & sync2.aux_hv_pin; // R3
    mon_view[MON_BUF_EN]    = sync2.buf_en;                          // R4
    mon_view[MON_LVF]       = next_lvf;                              // R5
    mon_view[2:0]           = next_shorts;
    next_mon = mon_view; // R15
  end

  // Change capture and indirect transfer engine
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_data    = data;
    next_sta_sel = sta_sel;
    next_fail    = fail;
    // Latch changes until handed to software
    next_sta     = sta | (mon ^ next_mon); // R10 R16
    unique case (state)
      HVM_IDLE: begin
        if (hv_interrupt_line) begin
          next_state   = HVM_XFER; // R12
          next_sta_sel = 1'b1;
          next_cnt     = CNT_W'(XFER_CNT - 1);
          next_fail    = 1'b0;
        end else if (cmd_valid) begin
          // Only status and monitor are reachable, never a bus address
          next_state   = HVM_XFER; // R11
          next_sta_sel = (cmd_code == CMD_READ_STA);
          next_fail    = (cmd_code != CMD_READ_STA)
                         && (cmd_code != CMD_READ_MON);
          next_cnt     = CNT_W'(XFER_CNT - 1);
        end
      end
      HVM_XFER: begin
        if (cnt == '0) begin
          next_state = HVM_IDLE; // R14
          if (!fail) begin
            next_data = sta_sel ? sta : mon;
            // Sampled bits are gone; fresh changes still latch
            if (sta_sel)
              next_sta = mon ^ next_mon; // R16
          end
        end else begin
          next_cnt = cnt - 1'b1; // R14
        end
      end
    endcase
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mon     <= MON_RESET;
      sta     <= STA_RESET;
      data    <= DATA_RESET;
      low_voltage_flag     <= 1'b0;
      shorts  <= '0;
      hot     <= 1'b0;
      state   <= HVM_IDLE;
      cnt     <= '0;
      sta_sel <= 1'b0;
      fail    <= 1'b0;
    end else begin
      mon     <= next_mon;
      sta     <= next_sta;
      data    <= next_data;
      low_voltage_flag     <= next_lvf;
      shorts  <= next_shorts;
      hot     <= next_hot;
      state   <= next_state;
      cnt     <= next_cnt;
      sta_sel <= next_sta_sel;
      fail    <= next_fail;
    end
  end

  // Busy shows for the whole transfer so software can poll it
  assign hv_command_reg[CON_BUSY] = (state == HVM_XFER); // R14
  assign hv_command_reg[CON_FAIL] = fail;
  assign hv_data_reg              = data;
  assign hv_live_monitor          = mon;
  assign hv_change_status         = sta;
  // Held off while busy so one event gives one transfer
  assign hv_interrupt_line = irq_enable && (sta != '0)
                             && (state == HVM_IDLE); // R17 R13

  // Assertions
  a_busy_len: assert property (@(posedge clk) disable iff (!reset_n) // R14
    (state == HVM_IDLE && next_state == HVM_XFER) |=>
      (hv_command_reg[CON_BUSY] [*8]))
    else $error("busy dropped too early");
  a_irq_cause: assert property (@(posedge clk) disable iff (!reset_n) // R17
    hv_interrupt_line |-> (irq_enable && sta != 8'h00))
    else $error("interrupt without status");
  a_irq_xfer: assert property (@(posedge clk) disable iff (!reset_n) // R12
    hv_interrupt_line |=> sta_sel && hv_command_reg[CON_BUSY])
    else $error("interrupt did not start transfer");
  a_change_rec: assert property (@(posedge clk) disable iff (!reset_n) // R10
    (mon != $past(mon)) |-> ((sta & (mon ^ $past(mon))) ==
                             (mon ^ $past(mon))))
    else $error("change not recorded");
  a_pin_mask: assert property (@(posedge clk) disable iff (!reset_n) // R1 R3
    !$past(cfg.pin_input_mode) |-> !mon[MON_WAKE_PIN]
      && !mon[MON_AUX_PIN])
    else $error("pin readback outside input mode");
  a_hot_sticky: assert property (@(posedge clk) disable iff (!reset_n) // R2
    mon[MON_OVERTEMP] |=> mon[MON_OVERTEMP])
    else $error("overtemperature bit fell");
  a_short_hold: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (mon[MON_BUS_SHORT] && !cfg.short_clear) |=> mon[MON_BUS_SHORT])
    else $error("bus short cleared without config write");
  a_aux_short: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (mon[MON_AUX_SHORT] && !cfg.short_clear) |=> mon[MON_AUX_SHORT])
    else $error("aux short cleared without config write");
  a_lvf_rearm: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (!low_voltage_flag && next_lvf) |-> cfg.lvf_enable_wr)
    else $error("flag set without re-enable");
  a_data_load: assert property (@(posedge clk) disable iff (!reset_n) // R12
    $fell(hv_command_reg[CON_BUSY]) && !$past(fail) && $past(sta_sel)
      |-> hv_data_reg == $past(sta))
    else $error("status not copied to data");

  c_irq_xfer: cover property (@(posedge clk) disable iff (!reset_n)
    hv_interrupt_line ##1 hv_command_reg[CON_BUSY]);
  c_mon_read: cover property (@(posedge clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_READ_MON && state == HVM_IDLE);
  c_short_clr: cover property (@(posedge clk) disable iff (!reset_n)
    mon[MON_BUS_SHORT] && cfg.short_clear);

endmodule

// *** dv/hv_monitor_status_regs_bench.sv ***
/*
  Self-checking bench for the monitor and status bank.
  Assumes hvm_regs with a short transfer count and the core model.
*/
`timescale 1ns/100ps
module hv_monitor_status_regs_bench
  import hvm_pkg::*;
;
  localparam int XF = 8;  // Short transfer keeps the run brief
  logic clk, reset_n, irq_enable, cmd_valid, go, done, line;
  logic [1:0] cmd_code, code, lazy, cmd_reg;
  logic [7:0] data, mon, sta, mon_exp, sta_exp, r;
  logic [8:0] rdata;
  logic [8:0] expq[$];
  logic [15:0] bc;
  hvm_cond_t cond;
  hvm_cfg_t cfg;
  int miscompares, n_checks;

  hvm_regs #(.XFER_CNT(XF)) dut (.clk(clk), .reset_n(reset_n),
    .cond_raw(cond), .cfg(cfg), .irq_enable(irq_enable),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .hv_data_reg(data),
    .hv_command_reg(cmd_reg), .hv_interrupt_line(line),
    .hv_live_monitor(mon), .hv_change_status(sta));
  hvm_core_model core (.clk(clk), .go(go), .code(code), .lazy(lazy),
    .hv_command_reg(cmd_reg), .hv_data_reg(data),
    .hv_interrupt_line(line), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .done(done), .rdata(rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for the core to hand back a result
  task automatic wait_done();
    for (int n = 0; n < 100 && done !== 1'b1; n++) @(posedge clk);
    check({15'h0, done}, 16'h0001);
    @(posedge clk);
    #2;
  endtask

  task automatic rd(input logic [1:0] c, input logic [8:0] e);
    expq.push_back(e);
    code = c;
    go = 1'b1;
    @(posedge clk);
    #2 go = 1'b0;
    wait_done();
  endtask

  // Let the 2-flop sync settle, note changes, then read the monitor
  task automatic step(input logic [7:0] m);
    repeat (5) @(posedge clk);
    #2 sta_exp = sta_exp | (mon_exp ^ m);
    mon_exp = m;
    rd(CMD_READ_MON, {1'b0, m});
  endtask

  // Oldest note is compared when the core returns a result
  always @(posedge clk) if (done === 1'b1)
    check({7'h0, rdata}, {7'h0, expq.pop_front()});

  // Busy must stand exactly the transfer count
  always @(posedge clk) begin
    if (cmd_reg[CON_BUSY] === 1'b1) bc++;
    else if (bc != 0) begin
      check(bc, 16'(XF));
      bc = 0;
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 5000);
    miscompares++;
    wrap_up();
  end

  initial begin
    {reset_n, irq_enable, go, code, lazy, cfg, bc} = '0;
    cond = '0;
    cond.lv_ok = 1'b1;  // Supply healthy from power-up
    {mon_exp, sta_exp} = '0;
    void'($urandom(30));
    repeat (3) @(posedge clk);
    #2 reset_n = 1'b1;
    check({8'h00, sta}, 16'h0000);
    rd(CMD_READ_MON, 9'h000);
    cfg.pin_input_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = 8'($urandom());
      {cond.wake_pin, cond.aux_hv_pin, cond.buf_en} = r[2:0];
      cond.wake_short = r[3];
      lazy = r[5:4];  // Core answers promptly or slowly
      step({r[2], 1'b0, r[1], r[0], 4'h0} | {7'h0, r[3]});
    end
    cond = '{lv_ok: 1'b1, default: 1'b0};
    step(8'h00);
    // Short flags stick after the raw condition goes away
    {cond.bus_short, cond.aux_short} = 2'b11;
    step(8'h06);
    {cond.bus_short, cond.aux_short} = 2'b00;
    step(8'h06);
    cfg.short_clear = 1'b1;
    @(posedge clk);
    #2 cfg.short_clear = 1'b0;
    step(8'h00);
    cond.over_temp = 1'b1;
    step(8'h40);
    cond.over_temp = 1'b0;
    step(8'h40);
    {cfg.lvf_enable, cfg.lvf_enable_wr} = 2'b11;
    @(posedge clk);
    #2 cfg.lvf_enable_wr = 1'b0;
    step(8'h48);
    cond.lv_ok = 1'b0;
    step(8'h40);
    cond.lv_ok = 1'b1;
    step(8'h40);
    cfg.lvf_enable_wr = 1'b1;
    @(posedge clk);
    #2 cfg.lvf_enable_wr = 1'b0;
    step(8'h48);
    check({8'h00, sta}, {8'h00, sta_exp});
    check({15'h0, line}, 16'h0000);
    expq.push_back({1'b0, sta_exp});
    irq_enable = 1'b1;
    #1 check({15'h0, line}, 16'h0001);
    wait_done();
    check({7'h0, line, sta}, 16'h0000);
    rd(2'h3, {1'b1, sta_exp});
    // Handler reads status after the interrupt; already handed over
    rd(CMD_READ_STA, 9'h000);
    check(16'(expq.size()), 16'h0000);
    wrap_up();
  end
endmodule

// *** dv/hvm_core_model.sv ***
/*
  Processor-core model: asks for indirect reads and polls busy.
  Assumes the bank runs on clk; requests change 2 ns after an edge.
*/
`timescale 1ns/100ps
module hvm_core_model
  import hvm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [1:0] code,
  input  wire logic [1:0] lazy,
  input  wire logic [1:0] hv_command_reg,
  input  wire logic [7:0] hv_data_reg,
  input  wire logic       hv_interrupt_line,
  output logic            cmd_valid,
  output logic      [1:0] cmd_code,
  output logic            done,
  output logic      [8:0] rdata
);
  // One transfer at a time; a slow core waits before it asks
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 2'h0;
    done      = 1'b0;
    rdata     = 9'h000;
    forever begin
      @(posedge clk);
      if (go === 1'b1 || hv_interrupt_line === 1'b1) begin
        if (go === 1'b1) begin
          repeat (lazy) @(posedge clk);
          #2 cmd_valid = 1'b1;
          cmd_code = code;
          @(posedge clk);
          #2 cmd_valid = 1'b0;
          cmd_code = ~code;  // Old code must not linger on the lines
        end
        @(posedge clk);
        #2;
        // Data is only trusted once busy has dropped
        while (hv_command_reg[CON_BUSY] === 1'b1) begin
          @(posedge clk);
          #2;
        end
        done  = 1'b1;
        rdata = {hv_command_reg[CON_FAIL], hv_data_reg};
        @(posedge clk);
        #2 done = 1'b0;
      end
    end
  end
endmodule

// *** pkg/hvm_pkg.sv ***
/*
  Constants and carriers for the high-voltage monitor and status bank.
  Assumes a 40 MHz system clock; all users import the whole package.
*/
package hvm_pkg;

  // Clock and timing
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          XFER_TIME_NS    = 10_000;  // Auto transfer, 10 us
  localparam int          XFER_CYCLES     =
    (XFER_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          CNT_W           = 10;

  // Monitor bit positions
  localparam int          MON_WAKE_PIN    = 7;
  localparam int          MON_OVERTEMP    = 6;
  localparam int          MON_AUX_PIN     = 5;
  localparam int          MON_BUF_EN      = 4;
  localparam int          MON_LVF         = 3;
  localparam int          MON_BUS_SHORT   = 2;
  localparam int          MON_AUX_SHORT   = 1;
  localparam int          MON_WAKE_SHORT  = 0;

  // Reset values
  localparam logic [7:0]  MON_RESET       = 8'h00;
  localparam logic [7:0]  STA_RESET       = 8'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;

  // Indirect command codes
  localparam logic [1:0]  CMD_READ_MON    = 2'h1;
  localparam logic [1:0]  CMD_READ_STA    = 2'h2;

  // Command register status bits
  localparam int          CON_BUSY        = 0;
  localparam int          CON_FAIL        = 1;

  // Raw high-voltage conditions from the analog side
  typedef struct packed {
    logic wake_pin;
    logic over_temp;
    logic aux_hv_pin;
    logic buf_en;
    logic lv_ok;
    logic bus_short;
    logic aux_short;
    logic wake_short;
  } hvm_cond_t;

  // Configuration bits used by this bank
  typedef struct packed {
    logic pin_input_mode;   // config one bit 4
    logic short_clear;      // config one bit 3 write strobe
    logic lvf_enable;       // config zero bit 2
    logic lvf_enable_wr;    // config zero write strobe
  } hvm_cfg_t;

  typedef enum logic [1:0] {
    HVM_IDLE,
    HVM_XFER
  } hvm_state_t;

endpackage
